// ---- dbc_breakpoints.sv ----
// Breakpoint registers and comparators of the debug engine.
// Assumes decoded background read/write strobes from the TAP side and
// one cpu_step pulse per executed instruction with its buses valid.
//
// How it works
// - Six host-configurable breakpoint registers exist.
// - First four are 16-bit program address breakpoints.
// - Program address equal to register forces break.
// - Last two: data address or register breakpoint.
// - Registers accessed only by background host commands.
// - Debug enable compares program addresses every instruction.
// - Program match hands CPU over to debug.
// - Select low: compare against data address bus.
// - Select high: compare destination module and index.
// - Bits 3:0 module, 8:4 index, rest unused.
// - Data address match hands CPU to debug.
// - All registers reset to ones, also TAP reset.
// - Enable gates all; select picks last two's mode.
// - Prefix-activating match defers break to the next non-prefixed instruction.
// - Break turns status from non-debug to debug-idle.
`timescale 1ns/100ps
`include "dbc_cfg.svh"

module dbc_breakpoints import dbc_pkg::*; #(
    parameter int NUM_BP = `DBC_NUM_BP,
    parameter int NUM_PROG = `DBC_NUM_PROG
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tap_logic_reset,
    input wire logic bg_wr,
    input wire logic bg_rd,
    input wire logic [`DBC_SEL_WIDTH-1:0] bg_sel,
    input wire dbc_word_t bg_wdata,
    output dbc_word_t bg_rdata,
    output logic bg_rvalid,
    input wire logic debug_enable_bit,
    input wire logic register_break_select,
    input wire logic cpu_step,
    input wire dbc_word_t prog_addr,
    input wire logic data_addr_valid,
    input wire dbc_word_t data_addr,
    input wire logic dest_valid,
    input wire logic [`DBC_MOD_MSB:`DBC_MOD_LSB] dest_module,
    input wire logic [`DBC_IDX_MSB-`DBC_IDX_LSB:0] dest_index,
    input wire logic prefix_set,
    input wire logic debug_exit,
    output logic break_req,
    output logic [NUM_BP-1:0] break_source,
    output dbc_status_t status_bits
);
    dbc_word_t bp [NUM_BP];
    dbc_state_t state;
    dbc_state_t next_state;
    logic [NUM_BP-1:0] hit;

    // Host access decode; selectors past the last register are ignored
    wire sel_ok = (bg_sel < `DBC_SEL_WIDTH'(NUM_BP));
    wire wr_hit = bg_wr && sel_ok;
    wire dbc_word_t rd_word = sel_ok ? bp[bg_sel] : `DBC_RD_IDLE;

    // Storage; TAP logic reset outranks a write in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn || tap_logic_reset) begin
            for (int k = 0; k < NUM_BP; k++) begin
                bp[k] <= `DBC_BP_RESET;
            end
        end else if (wr_hit) begin
            bp[bg_sel] <= bg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bg_rdata <= `DBC_RD_IDLE;
            bg_rvalid <= 1'b0;
        end else begin
            bg_rdata <= bg_rd ? rd_word : bg_rdata;
            bg_rvalid <= bg_rd;
        end
    end

    // Shared probe of the two dual-mode comparators
    wire dbc_word_t reg_probe =
        {7'h00, dest_index, dest_module};
    wire dbc_word_t dual_probe =
        register_break_select ? reg_probe : data_addr;
    wire dbc_word_t dual_mask =
        register_break_select ? `DBC_REG_MASK : `DBC_FULL_MASK;
    wire dual_valid = cpu_step &&
        (register_break_select ? dest_valid : data_addr_valid);

    genvar g;
    generate
        for (g = 0; g < NUM_BP; g++) begin : g_cmp
            if (g < NUM_PROG) begin : g_prog
                dbc_cmp u_cmp (
                    .value(bp[g]),
                    .probe(prog_addr),
                    .mask(`DBC_FULL_MASK),
                    .probe_valid(cpu_step),
                    .hit(hit[g])
                );
            end else begin : g_dual
                dbc_cmp u_cmp (
                    .value(bp[g]),
                    .probe(dual_probe),
                    .mask(dual_mask),
                    .probe_valid(dual_valid),
                    .hit(hit[g])
                );
            end
        end
    endgenerate

    wire any_hit = debug_enable_bit && (|hit);
    wire take_break = (next_state == DBC_DEBUG) && (state != DBC_DEBUG);

    // Matches in debug mode are ignored until the host returns
    always_comb begin
        next_state = state;
        unique case (state)
            DBC_RUN: begin
                if (any_hit) begin
                    // Prefix must finish with its operation first
                    next_state = prefix_set ?
                        DBC_HOLD : DBC_DEBUG;
                end
            end
            DBC_HOLD: begin
                if (!debug_enable_bit) begin
                    next_state = DBC_RUN;
                end else if (cpu_step && !prefix_set) begin
                    next_state = DBC_DEBUG;
                end
            end
            DBC_DEBUG: begin
                if (debug_exit) begin
                    next_state = DBC_RUN;
                end
            end
            default: next_state = DBC_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= DBC_RUN;
            break_req <= 1'b0;
            break_source <= '0;
            status_bits <= `DBC_ST_NONDEBUG;
        end else begin
            state <= next_state;
            break_req <= take_break;
            if (state == DBC_RUN && any_hit) begin
                break_source <= hit;
            end
            status_bits <= (next_state == DBC_DEBUG) ?
                `DBC_ST_DEBUG_IDLE : `DBC_ST_NONDEBUG;
        end
    end

    wire prog0_hit = cpu_step && (prog_addr == bp[0]);

    a_no_break_off: assert property (
        @(posedge clk) disable iff (!rstn)
        !debug_enable_bit |=> !break_req)
        else $error("break raised with debug disabled");

    a_prog_match: assert property (
        @(posedge clk) disable iff (!rstn)
        state == DBC_RUN && debug_enable_bit && prog0_hit && !prefix_set
        |=> break_req && status_bits == `DBC_ST_DEBUG_IDLE)
        else $error("program match gave no break");

    a_data_match: assert property (
        @(posedge clk) disable iff (!rstn)
        state == DBC_RUN && debug_enable_bit && !register_break_select &&
        cpu_step && data_addr_valid && data_addr == bp[4] && !prefix_set
        |=> break_req)
        else $error("data address match gave no break");

    a_reg_match: assert property (
        @(posedge clk) disable iff (!rstn)
        state == DBC_RUN && debug_enable_bit && register_break_select &&
        cpu_step && dest_valid && reg_probe[8:0] == bp[5][8:0] &&
        !prefix_set
        |=> break_req ##1 !break_req)
        else $error("register match gave no single break");

    a_prefix_defer: assert property (
        @(posedge clk) disable iff (!rstn)
        state == DBC_RUN && any_hit && prefix_set
        |=> !break_req && state == DBC_HOLD)
        else $error("prefixed match did not defer");

    a_status_debug: assert property (
        @(posedge clk) disable iff (!rstn)
        break_req |-> status_bits == `DBC_ST_DEBUG_IDLE &&
        $past(status_bits) == `DBC_ST_NONDEBUG)
        else $error("status did not move to debug idle");

    a_reset_ones: assert property (
        @(posedge clk) disable iff (!rstn)
        tap_logic_reset |=> bp[0] == `DBC_BP_RESET &&
        bp[5] == `DBC_BP_RESET)
        else $error("breakpoints not reset to ones");

    a_write_store: assert property (
        @(posedge clk) disable iff (!rstn)
        bg_wr && bg_sel == 3'h2 && !tap_logic_reset
        |=> bp[2] == $past(bg_wdata))
        else $error("host write not stored");

    a_read_return: assert property (
        @(posedge clk) disable iff (!rstn)
        bg_rd |=> bg_rvalid && bg_rdata == $past(rd_word))
        else $error("host read returned wrong word");

    a_debug_quiet: assert property (
        @(posedge clk) disable iff (!rstn)
        state == DBC_DEBUG && !debug_exit |=> !break_req [*2])
        else $error("break repeated in debug mode");
endmodule // dbc_breakpoints

// ---- dbc_cfg.svh ----
// Constants of the breakpoint comparator block: reset values, field
// positions, masks and status codes. Definitions only.
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH

`define DBC_NUM_BP 6
`define DBC_NUM_PROG 4
`define DBC_BP_WIDTH 16
`define DBC_SEL_WIDTH 3
`define DBC_BP_RESET 16'hFFFF
`define DBC_FULL_MASK 16'hFFFF
`define DBC_REG_MASK 16'h01FF
`define DBC_MOD_LSB 0
`define DBC_MOD_MSB 3
`define DBC_IDX_LSB 4
`define DBC_IDX_MSB 8
`define DBC_RD_IDLE 16'h0000
`define DBC_ST_NONDEBUG 2'h0
`define DBC_ST_DEBUG_IDLE 2'h1

`endif

// ---- dbc_pkg.sv ----
// Types shared by the breakpoint comparator block.
// Assumes dbc_cfg.svh is on the include path.
`include "dbc_cfg.svh"

package dbc_pkg;
    typedef logic [`DBC_BP_WIDTH-1:0] dbc_word_t;
    typedef logic [1:0] dbc_status_t;
    typedef enum logic [2:0] {
        DBC_RUN = 3'h1,
        DBC_HOLD = 3'h2,
        DBC_DEBUG = 3'h4
    } dbc_state_t;
endpackage

// ---- dbc_cmp.sv ----
// One masked equality comparator between a breakpoint word and a probe.
// Assumes probe and its valid are stable in the cycle they are sampled.
`timescale 1ns/100ps

module dbc_cmp import dbc_pkg::*; (
    input wire dbc_word_t value,
    input wire dbc_word_t probe,
    input wire dbc_word_t mask,
    input wire logic probe_valid,
    output logic hit
);
    wire dbc_word_t diff = (value ^ probe) & mask;

    assign hit = probe_valid && (diff == '0);
endmodule // dbc_cmp

// ---- dbc_cpu_model.sv ----
// CPU side model: one executed instruction per go pulse from the bench.
// Assumes go and its qualifiers change just after a rising clk edge.
`timescale 1ns/100ps

module dbc_cpu_model import dbc_pkg::*; (
    input wire logic clk,
    input wire logic go,
    input wire logic prefix_register,
    input wire logic dv,
    input wire logic tv,
    input wire dbc_word_t pa,
    input wire dbc_word_t da,
    input wire logic [8:0] dst,
    output logic cpu_step,
    output dbc_word_t prog_addr,
    output logic data_addr_valid,
    output dbc_word_t data_addr,
    output logic dest_valid,
    output logic [3:0] dest_module,
    output logic [4:0] dest_index,
    output logic prefix_set
);
    dbc_word_t last_pa;
    dbc_word_t last_da;
    logic [8:0] last_dst;
    always_ff @(posedge clk) begin
        if (go) begin
            last_pa <= pa;
            last_da <= da;
            last_dst <= dst;
        end
    end
    // Idle buses show inverted data, so a stale value never matches
    assign cpu_step = go;
    assign prog_addr = go ? pa : ~last_pa;
    assign data_addr = go ? da : ~last_da;
    assign {dest_index, dest_module} = go ? dst : ~last_dst;
    assign data_addr_valid = go & dv;
    assign dest_valid = go & tv;
    assign prefix_set = go & prefix_register;
endmodule // dbc_cpu_model

// ---- test_dbc_breakpoints.sv ----
// Self-checking bench of the breakpoint comparators.
// Assumes dbc_pkg and dbc_cpu_model are compiled before this file.
`timescale 1ns/100ps

module test_dbc_breakpoints import dbc_pkg::*;;
    logic clk, rstn, tap_logic_reset, bg_wr, bg_rd, bg_rvalid, break_req;
    logic debug_enable_bit, register_break_select, debug_exit, go, prefix_register;
    logic dv, tv, cpu_step, data_addr_valid, dest_valid, prefix_set;
    logic [2:0] bg_sel;
    dbc_word_t bg_wdata, bg_rdata, pa, da, prog_addr, data_addr;
    logic [8:0] dst;
    logic [3:0] dest_module;
    logic [4:0] dest_index;
    logic [5:0] break_source, held;
    dbc_status_t status_bits;
    int n_fail, total_checks, cycles, seed;
    int bp[6];

    dbc_breakpoints dbc_breakpoints_i (.clk, .rstn, .tap_logic_reset,
        .bg_wr, .bg_rd, .bg_sel, .bg_wdata, .bg_rdata, .bg_rvalid,
        .debug_enable_bit, .register_break_select, .cpu_step, .prog_addr,
        .data_addr_valid, .data_addr, .dest_valid, .dest_module,
        .dest_index, .prefix_set, .debug_exit, .break_req, .break_source,
        .status_bits);
    dbc_cpu_model dbc_cpu_model_i (.clk, .go, .prefix_register, .dv, .tv, .pa, .da,
        .dst, .cpu_step, .prog_addr, .data_addr_valid, .data_addr,
        .dest_valid, .dest_module, .dest_index, .prefix_set);

    task automatic summarize;
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic ok);
        total_checks++;
        if (!ok) begin
            n_fail++;
            $display("Error at %0t: output differs from model", $time);
        end
    endtask

    task automatic wr(input logic [2:0] s, input int d);
        @(posedge clk);
        #1 bg_wr = 1;
        bg_sel = s;
        bg_wdata = d[15:0];
        @(posedge clk);
        #1 bg_wr = 0;
    endtask

    task automatic rd(input logic [2:0] s, input int e);
        @(posedge clk);
        #1 bg_rd = 1;
        bg_sel = s;
        @(posedge clk);
        #1 bg_rd = 0;
        chk(bg_rvalid === 1'b1 && bg_rdata === e[15:0]);
    endtask

    // One instruction; model decides the hits, then the break follows
    task automatic step(input logic p);
        logic [5:0] s;
        s = 0;
        for (int i = 0; i < 6; i++) begin
            if (i < 4)
                s[i] = bp[i] == pa;
            else if (register_break_select)
                s[i] = tv && bp[i][8:0] == dst;
            else
                s[i] = dv && bp[i] == da;
        end
        if (!debug_enable_bit) begin
            s = 0;
            held = 0;
        end
        if (held == 0)
            held = s;
        @(posedge clk);
        #1 go = 1;
        prefix_register = p;
        @(posedge clk);
        #1 go = 0;
        chk(break_req === (held != 0 && !p));
        if (held != 0 && !p) begin
            chk(break_source === held && status_bits === 2'h1);
            held = 0;
            debug_exit = 1;
            @(posedge clk);
            #1 debug_exit = 0;
            chk(status_bits === 2'h0);
        end
    endtask

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        seed = 32'h28C8130B;
        {rstn, tap_logic_reset, bg_wr, bg_rd, debug_exit, go, prefix_register} = 0;
        {debug_enable_bit, register_break_select} = 0;
        {dv, tv, bg_sel, bg_wdata, pa, da, dst, held} = 0;
        repeat (3) @(posedge clk);
        #1 rstn = 1;
        for (int i = 0; i < 8; i++)
            rd(3'(i), i < 6 ? 16'hFFFF : 0);
        for (int i = 0; i < 6; i++) begin
            bp[i] = $random(seed) & 16'hFFFF;
            wr(3'(i), bp[i]);
            rd(3'(i), bp[i]);
        end
        wr(3'h6, 16'h1234);
        rd(3'h6, 0);
        dv = 1;
        tv = 1;
        for (int e = 0; e < 2; e++) begin
            debug_enable_bit = e[0];
            for (int i = 0; i < 6; i++) begin
                register_break_select = i == 5;
                pa = i < 4 ? bp[i][15:0] : 16'($random(seed));
                da = i == 4 ? bp[4][15:0] : 16'($random(seed));
                dst = i == 5 ? bp[5][8:0] : 9'($random(seed));
                step(0);
            end
        end
        register_break_select = 0;
        pa = bp[1][15:0];
        step(1);
        pa = ~pa;
        step(0);
        // Enable dropped while a prefixed break is pending cancels it
        pa = bp[2][15:0];
        step(1);
        debug_enable_bit = 0;
        step(0);
        debug_enable_bit = 1;
        // TAP reset must win over a write in the same cycle
        tap_logic_reset = 1;
        wr(3'h3, 16'h1234);
        tap_logic_reset = 0;
        for (int i = 0; i < 6; i++)
            rd(3'(i), 16'hFFFF);
        summarize();
    end
endmodule // test_dbc_breakpoints
